// ### core/ssc_core.sv
// Serial unit top: AHB-Lite registers, transmitter, receiver, clock pin
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ssc_core
   import ssc_pkg::*;
(
   input wire logic hclk, // Peripheral clock, 25 MHz
   input wire logic hresetn, // Asynchronous reset, active low
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Byte address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write when high
   input wire logic [2:0] hsize, // Transfer size, word only
   input wire logic hready, // Bus ready in
   input wire logic [31:0] hwdata, // Write data
   output logic [31:0] hrdata, // Read data
   output logic hreadyout, // Slave ready
   output logic hresp, // Always OKAY
   output logic txd_o, // Transmit line
   output logic txd_oe, // Transmit line drive enable
   input wire logic rxd_i, // Receive line
   input wire logic sck_i, // Serial clock pin in
   output logic sck_o, // Serial clock pin out
   output logic sck_oe // Serial clock pin drive enable
);
   logic [7:0] fmt_q, rate_q, ctrl_q, txhold_q, rxhold_q;
   logic tx_empty_q, tx_end_q, addr_tx_q, rx_full_q, ovr_q, frm_q;
   logic par_q, addr_rx_q, brk_q;
   logic wr_pend_q, rd_pend_q;
   logic [7:0] wr_addr_q, rd_addr_q;
   logic [31:0] rd_word;
   logic wr_fmt, wr_rate, wr_ctrl, wr_txh, wr_stat, acc;
   logic sync, ext, tx_on, rx_on, seven, has_x, bg_tick, half_q, tick16;
   logic sck_prev_q, sck_rise, sck_fall, s_rise, s_fall, sync_run;
   logic [1:0] q4_q;
   logic [3:0] ph16_q, ph16_next;
   ssc_tx_st_t tx_st_q;
   logic [11:0] tx_sr_q, frame;
   logic [3:0] tx_left_q, tx_nbits, dlen;
   logic tx_step, tx_par, xb, txd_q;
   ssc_rx_st_t rx_st_q;
   logic [9:0] rx_sr_q, rx_shift, rx_al;
   logic [3:0] rx_cnt_q, rx_left_q, rx_m;
   logic [7:0] rx_data;
   logic rx_x, rx_fin, rxd_prev_q, rx_err, rx_bad_par;

   logic [31:0] rd_word_q;
   logic hreadyout_q;
   assign hrdata = rd_word_q;
   assign hreadyout = hreadyout_q;
   assign hresp = 1'b0;
   assign txd_o = txd_q;
   assign txd_oe = tx_on;
   logic sck_o_q, sck_oe_q;
   assign sck_o = sck_o_q;
   assign sck_oe = sck_oe_q;

   // Mode decode from the stored format and control bits
   assign sync = fmt_q[FMT_SYNC];
   assign ext = ctrl_q[CTL_CLK_HI];
   assign tx_on = ctrl_q[CTL_TX_ON];
   assign rx_on = ctrl_q[CTL_RX_ON];
   assign seven = fmt_q[FMT_SEVEN] & ~sync;
   assign has_x = ~sync & (fmt_q[FMT_ADDR] | fmt_q[FMT_PARITY]);
   assign dlen = seven ? 4'h7 : 4'h8;

   // AHB-Lite slave: writes commit at the end of the data phase, reads
   // add one wait state so a read right after a write sees the new value
   assign acc = hsel & hready & htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rd_addr_q <= 8'h00;
         hreadyout_q <= 1'b1;
         rd_word_q <= 32'h0000_0000;
      end else begin
         wr_pend_q <= acc & hwrite;
         rd_pend_q <= acc & ~hwrite;
         if (acc) begin
            wr_addr_q <= haddr[7:0];
            rd_addr_q <= haddr[7:0];
         end
         hreadyout_q <= ~(acc & ~hwrite);
         if (rd_pend_q) begin
            rd_word_q <= rd_word;
         end
      end
   end
   assign wr_fmt = wr_pend_q & (wr_addr_q == OFF_FORMAT);
   assign wr_rate = wr_pend_q & (wr_addr_q == OFF_BIT_RATE);
   assign wr_ctrl = wr_pend_q & (wr_addr_q == OFF_CONTROL);
   assign wr_txh = wr_pend_q & (wr_addr_q == OFF_TX_HOLD);
   assign wr_stat = wr_pend_q & (wr_addr_q == OFF_STATUS);

   // Read mux; unmapped addresses read as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      case (rd_addr_q)
         OFF_FORMAT: rd_word[7:0] = fmt_q;
         OFF_BIT_RATE: rd_word[7:0] = rate_q;
         OFF_CONTROL: rd_word[7:0] = ctrl_q;
         OFF_TX_HOLD: rd_word[7:0] = txhold_q;
         OFF_STATUS: rd_word[8:0] = {brk_q, tx_empty_q, rx_full_q, ovr_q,
            frm_q, par_q, tx_end_q, addr_rx_q, addr_tx_q};
         OFF_RX_HOLD: rd_word[7:0] = rxhold_q;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // Software-written registers; rate readable and writable at any time
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fmt_q <= RST_FORMAT;
         rate_q <= RST_BIT_RATE;
         ctrl_q <= RST_CONTROL;
         txhold_q <= RST_DATA;
      end else begin
         if (wr_fmt) fmt_q <= hwdata[7:0];
         if (wr_rate) rate_q <= hwdata[7:0];
         if (wr_ctrl) ctrl_q <= hwdata[7:0];
         if (wr_txh) txhold_q <= hwdata[7:0];
      end
   end

   ssc_baud_gen u_baud (
      .hclk(hclk),
      .hresetn(hresetn),
      .presc(fmt_q[FMT_PRESC_HI:FMT_PRESC_LO]),
      .divisor(rate_q),
      .tick_q(bg_tick)
   );

   // Clock sources: generator runs at 32x bit rate in async, halved to 16x;
   // the pin is taken as synchronous, so one register finds its edges
   assign sck_rise = sck_i & ~sck_prev_q;
   assign sck_fall = ~sck_i & sck_prev_q;
   assign tick16 = ext ? sck_rise : (bg_tick & half_q);
   assign ph16_next = tick16 ? ph16_q + 4'h1 : ph16_q;
   assign s_fall = ext ? sck_fall : (bg_tick & sync_run &
      (q4_q == SYNC_FALL_PH));
   assign s_rise = ext ? sck_rise : (bg_tick & sync_run &
      (q4_q == SYNC_RISE_PH));
   assign sync_run = sync & ~ext & ((tx_st_q == TX_RUN) |
      (tx_on & ~tx_empty_q) | (rx_on & ~rx_full_q & ~ovr_q));
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sck_prev_q <= 1'b1;
         half_q <= 1'b0;
         ph16_q <= 4'h0;
         q4_q <= 2'h0;
      end else begin
         sck_prev_q <= sck_i;
         if (bg_tick) half_q <= ~half_q;
         ph16_q <= ph16_next;
         if (!sync_run) q4_q <= 2'h0;
         else if (bg_tick) q4_q <= q4_q + 2'h1;
      end
   end

   // Clock pin: enable follows control one cycle later, async out rises mid bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sck_oe_q <= 1'b0;
         sck_o_q <= 1'b1;
      end else begin
         sck_oe_q <= sync ? ~ext : (ctrl_q[CTL_CLK_HI:CTL_CLK_LO] == 2'h1);
         if (sync) begin
            if (!sync_run) sck_o_q <= 1'b1;
            else if (s_fall) sck_o_q <= 1'b0;
            else if (s_rise) sck_o_q <= 1'b1;
         end else begin
            sck_o_q <= ph16_next[3];
         end
      end
   end

   // Transmit frame: start, data LSB first, optional extra bit, stops
   assign tx_par = ^(seven ? {1'b0, txhold_q[6:0]} : txhold_q) ^
      fmt_q[FMT_ODD];
   assign xb = ~has_x | (fmt_q[FMT_ADDR] ? addr_tx_q : tx_par);
   assign frame = seven ? {3'b111, xb, txhold_q[6:0], 1'b0} :
      {2'b11, xb, txhold_q, 1'b0};
   assign tx_nbits = dlen + {3'h0, has_x} +
      (fmt_q[FMT_TWO_STOP] ? 4'h2 : 4'h1);
   assign tx_step = sync ? s_fall : (tick16 & (ph16_q == BIT_LAST_TICK));

   // Transmitter; set of a flag is written last so it beats a clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_st_q <= TX_IDLE;
         tx_sr_q <= 12'hfff;
         tx_left_q <= 4'h0;
         txd_q <= 1'b1;
         tx_empty_q <= 1'b1;
         tx_end_q <= 1'b1;
         addr_tx_q <= 1'b0;
      end else begin
         if (wr_stat && !hwdata[ST_TX_EMPTY]) tx_empty_q <= 1'b0;
         if (wr_stat && !hwdata[ST_TX_END]) tx_end_q <= 1'b0;
         if (wr_stat) addr_tx_q <= hwdata[ST_ADDR_TX];
         if (!tx_on) begin
            tx_st_q <= TX_IDLE;
            tx_sr_q <= 12'hfff;
            tx_left_q <= 4'h0;
            txd_q <= 1'b1;
            tx_empty_q <= 1'b1;
         end else if (tx_step) begin
            if (tx_left_q != 4'h0) begin
               txd_q <= tx_sr_q[0];
               tx_sr_q <= {1'b1, tx_sr_q[11:1]};
               tx_left_q <= tx_left_q - 4'h1;
            end else if (!tx_empty_q) begin
               tx_st_q <= TX_RUN;
               tx_empty_q <= 1'b1;
               tx_end_q <= 1'b0;
               if (sync) begin
                  txd_q <= txhold_q[0];
                  tx_sr_q <= {5'h1f, txhold_q[7:1]};
                  tx_left_q <= 4'h7;
               end else begin
                  txd_q <= 1'b0;
                  tx_sr_q <= {1'b1, frame[11:1]};
                  tx_left_q <= tx_nbits;
               end
            end else begin
               tx_st_q <= TX_IDLE;
               txd_q <= 1'b1;
               if (tx_st_q == TX_RUN) tx_end_q <= 1'b1;
            end
         end
      end
   end

   // Receive alignment: bits enter at the top, shifted down by RX_SR_W less frame size
   assign rx_m = sync ? 4'h8 : (dlen + {3'h0, has_x} + 4'h1);
   assign rx_shift = {rxd_i, rx_sr_q[9:1]};
   assign rx_al = rx_shift >> (RX_SR_W - rx_m);
   assign rx_data = seven ? {1'b0, rx_al[6:0]} : rx_al[7:0];
   assign rx_x = seven ? rx_al[7] : rx_al[8];
   assign rx_bad_par = ~sync & fmt_q[FMT_PARITY] & ~fmt_q[FMT_ADDR] &
      ((^rx_data ^ fmt_q[FMT_ODD]) != rx_x);
   assign rx_err = ovr_q | frm_q | par_q;
   // Gated by receive on so a frame ending as it is switched off is dropped
   assign rx_fin = rx_on & (rx_st_q == RX_DATA) & (rx_left_q == 4'h1) &
      (sync ? s_rise : (tick16 & (rx_cnt_q == BIT_LAST_TICK)));

   // Receiver engine; turning receive off only stops the engine
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_st_q <= RX_IDLE;
         rx_sr_q <= 10'h000;
         rx_cnt_q <= 4'h0;
         rx_left_q <= 4'h0;
         rxd_prev_q <= 1'b1;
      end else begin
         rxd_prev_q <= rxd_i;
         if (!rx_on || rx_err) begin
            rx_st_q <= RX_IDLE;
         end else begin
            case (rx_st_q)
               RX_IDLE: begin
                  rx_cnt_q <= 4'h0;
                  rx_left_q <= rx_m;
                  if (sync) rx_st_q <= RX_DATA;
                  else if (rxd_prev_q && !rxd_i) rx_st_q <= RX_START;
               end
               RX_START: begin
                  if (tick16) rx_cnt_q <= rx_cnt_q + 4'h1;
                  if (tick16 && rx_cnt_q == RX_MID_TICK) begin
                     rx_cnt_q <= 4'h0;
                     rx_st_q <= rxd_i ? RX_IDLE : RX_DATA;
                  end
               end
               RX_DATA: begin
                  if (!sync && tick16) rx_cnt_q <= rx_cnt_q + 4'h1;
                  if (sync ? s_rise : (tick16 && rx_cnt_q == BIT_LAST_TICK)) begin
                     rx_sr_q <= rx_shift;
                     rx_left_q <= rx_left_q - 4'h1;
                     if (rx_fin) rx_st_q <= RX_IDLE;
                  end
               end
               default: rx_st_q <= RX_IDLE;
            endcase
         end
      end
   end

   // Receive flags and holding register; hardware set beats software clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rxhold_q <= RST_DATA;
         rx_full_q <= 1'b0;
         ovr_q <= 1'b0;
         frm_q <= 1'b0;
         par_q <= 1'b0;
         brk_q <= 1'b0;
         addr_rx_q <= 1'b0;
      end else begin
         if (wr_stat && !hwdata[ST_RX_FULL]) rx_full_q <= 1'b0;
         if (wr_stat && !hwdata[ST_OVERRUN]) ovr_q <= 1'b0;
         if (wr_stat && !hwdata[ST_PARITY]) par_q <= 1'b0;
         if (wr_stat && !hwdata[ST_FRAMING]) begin
            frm_q <= 1'b0;
            brk_q <= 1'b0;
         end
         if (rx_fin && !rx_err) begin
            if (rx_full_q) begin
               ovr_q <= 1'b1;
            end else begin
               rxhold_q <= rx_data;
               if (!sync && !rxd_i) begin
                  frm_q <= 1'b1;
                  brk_q <= (rx_data == 8'h00) & ~(has_x & rx_x);
               end
               if (rx_bad_par) par_q <= 1'b1;
               if (!sync && fmt_q[FMT_ADDR]) addr_rx_q <= rx_x;
               if (sync || (rxd_i && !rx_bad_par)) rx_full_q <= 1'b1;
            end
         end
      end
   end

   // Checks kept beside the logic they guard
   a_tx_off_empty: assert property (@(posedge hclk) disable iff (!hresetn)
      !tx_on |=> tx_empty_q && tx_st_q == TX_IDLE && txd_q)
      else $error("transmit off did not empty and reset the shifter");
   a_rx_off_keep: assert property (@(posedge hclk) disable iff (!hresetn)
      (!rx_on && !wr_stat) |=> $stable(rxhold_q) && $stable(rx_full_q) &&
      $stable(ovr_q) && $stable(frm_q) && $stable(par_q))
      else $error("receive flags changed while receive off");
   a_async_start_low: assert property (@(posedge hclk) disable iff (!hresetn)
      (tx_on && !sync && tx_step && tx_left_q == 4'h0 && !tx_empty_q)
      |=> !txd_q && tx_left_q == $past(tx_nbits))
      else $error("async frame did not begin with a low start bit");
   a_sync_first_bit: assert property (@(posedge hclk) disable iff (!hresetn)
      (tx_on && sync && tx_step && tx_left_q == 4'h0 && !tx_empty_q)
      |=> txd_q == $past(txhold_q[0]) && tx_left_q == 4'h7)
      else $error("sync frame did not begin with data bit zero");
   a_idle_mark: assert property (@(posedge hclk) disable iff (!hresetn)
      tx_st_q == TX_IDLE && tx_left_q == 4'h0 |-> txd_q)
      else $error("idle transmit line not high");
   a_clk_out_phase: assert property (@(posedge hclk) disable iff (!hresetn)
      (!sync && tx_step) |=> !sck_o_q)
      else $error("async clock out not low at bit boundary");
   a_clk_out_on: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_ctrl && !sync && hwdata[CTL_CLK_HI:CTL_CLK_LO] == 2'h1)
      ##1 1'b1 |=> sck_oe_q)
      else $error("clock out not enabled after control write");
   a_sync_clk_drive: assert property (@(posedge hclk) disable iff (!hresetn)
      (sync && !ext) ##1 (sync && !ext) |-> sck_oe_q)
      else $error("sync internal clock not driven");
   a_mid_reject: assert property (@(posedge hclk) disable iff (!hresetn)
      (rx_on && !rx_err && rx_st_q == RX_START && tick16 &&
      rx_cnt_q == RX_MID_TICK && rxd_i) |=> rx_st_q == RX_IDLE)
      else $error("false start bit accepted");
   a_sync_no_frame: assert property (@(posedge hclk) disable iff (!hresetn)
      (sync && rx_fin) |=> $stable(frm_q) && $stable(par_q))
      else $error("sync receive raised framing or parity");
   a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      (acc && !hwrite) |=> !hreadyout_q ##1 hreadyout_q)
      else $error("read wait state not one cycle");
endmodule : ssc_core
`default_nettype wire

// ### core/ssc_pkg.sv
// Constants, register map and field layout of the serial unit
package ssc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_FORMAT = 8'h00;
   localparam logic [7:0] OFF_BIT_RATE = 8'h04;
   localparam logic [7:0] OFF_CONTROL = 8'h08;
   localparam logic [7:0] OFF_TX_HOLD = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_RX_HOLD = 8'h14;
   // Format register fields
   localparam int FMT_SYNC = 7;
   localparam int FMT_SEVEN = 6;
   localparam int FMT_PARITY = 5;
   localparam int FMT_ODD = 4;
   localparam int FMT_TWO_STOP = 3;
   localparam int FMT_ADDR = 2;
   localparam int FMT_PRESC_HI = 1;
   localparam int FMT_PRESC_LO = 0;
   // Control register fields
   localparam int CTL_TX_ON = 5;
   localparam int CTL_RX_ON = 4;
   localparam int CTL_CLK_HI = 1;
   localparam int CTL_CLK_LO = 0;
   // Status register fields
   localparam int ST_BREAK = 8;
   localparam int ST_TX_EMPTY = 7;
   localparam int ST_RX_FULL = 6;
   localparam int ST_OVERRUN = 5;
   localparam int ST_FRAMING = 4;
   localparam int ST_PARITY = 3;
   localparam int ST_TX_END = 2;
   localparam int ST_ADDR_RX = 1;
   localparam int ST_ADDR_TX = 0;
   // Reset values
   localparam logic [7:0] RST_FORMAT = 8'h00;
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_BIT_RATE = 8'hff;
   localparam logic [7:0] RST_DATA = 8'h00;
   // Prescaler terminal counts for divide by 1, 4, 16, 64
   localparam logic [5:0] PRESC_LIM_1 = 6'h00;
   localparam logic [5:0] PRESC_LIM_4 = 6'h03;
   localparam logic [5:0] PRESC_LIM_16 = 6'h0f;
   localparam logic [5:0] PRESC_LIM_64 = 6'h3f;
   // Bit timing (sixteen ticks per async bit, four phases per sync bit) and receive register width
   localparam logic [3:0] RX_MID_TICK = 4'h7;
   localparam logic [3:0] BIT_LAST_TICK = 4'hf;
   localparam logic [1:0] SYNC_FALL_PH = 2'h0;
   localparam logic [1:0] SYNC_RISE_PH = 2'h2;
   localparam logic [3:0] RX_SR_W = 4'ha;
   typedef enum logic [0:0] {TX_IDLE, TX_RUN} ssc_tx_st_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} ssc_rx_st_t;
endpackage : ssc_pkg

// ### core/ssc_baud_gen.sv
// Baud rate generator: prescaler followed by an eight-bit divider
`timescale 1ns/1ps
`default_nettype none
module ssc_baud_gen
   import ssc_pkg::*;
(
   input wire logic hclk, // Peripheral clock
   input wire logic hresetn, // Asynchronous reset, active low
   input wire logic [1:0] presc, // Prescaler choice
   input wire logic [7:0] divisor, // Rate register value
   output logic tick_q // One-cycle pulse per generator period
);
   logic [5:0] pre_cnt_q;
   logic [5:0] pre_lim;
   logic [7:0] div_cnt_q;
   logic pre_tick;

   // Prescaler terminal count from the format field
   always_comb begin
      case (presc)
         2'h0: pre_lim = PRESC_LIM_1;
         2'h1: pre_lim = PRESC_LIM_4;
         2'h2: pre_lim = PRESC_LIM_16;
         default: pre_lim = PRESC_LIM_64;
      endcase
   end
   assign pre_tick = (pre_cnt_q >= pre_lim);

   // Prescaler counter; >= keeps it sane if the choice shrinks mid count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_cnt_q <= 6'h00;
      end else if (pre_tick) begin
         pre_cnt_q <= 6'h00;
      end else begin
         pre_cnt_q <= pre_cnt_q + 6'h01;
      end
   end

   // Divide by rate value plus one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt_q <= 8'h00;
         tick_q <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (pre_tick) begin
            if (div_cnt_q >= divisor) begin
               div_cnt_q <= 8'h00;
               tick_q <= 1'b1;
            end else begin
               div_cnt_q <= div_cnt_q + 8'h01;
            end
         end
      end
   end
endmodule : ssc_baud_gen
`default_nettype wire

// ### tb/ssc_remote_model.sv
// Remote serial station: echoes the line, can hold a break, makes a clock
`timescale 1ns/1ps
`default_nettype none
module ssc_remote_model (
   input wire logic txd_o, // Transmit line of the unit
   input wire logic txd_oe, // Unit drives its transmit line
   input wire logic brk, // Hold the receive line low
   input wire logic ext_en, // Supply the external clock
   output logic rxd_i, // Receive line of the unit
   output logic sck_i // Clock offered on the serial clock pin
);
   // Echo own frames; a released line floats up through its pull-up
   assign rxd_i = brk ? 1'b0 : (txd_oe ? txd_o : 1'b1);
   // Clock toggles only while ext_en is high, phase unrelated to the bus clock
   initial begin
      sck_i = 1'b1;
      #13;
      forever begin
         #80;
         if (ext_en) sck_i = ~sck_i;
      end
   end
endmodule : ssc_remote_model
`default_nettype wire

// ### tb/ssc_core_tb_top.sv
// Testbench of the serial unit: bus tasks, frame checks, verdict
`timescale 1ns/1ps
`default_nettype none
module ssc_core_tb_top import ssc_pkg::*;;
   logic hclk, hresetn, hsel, hwrite, txd_o, txd_oe, rxd_i, rdy;
   logic hreadyout, hresp, sck_m, sck_o, sck_oe, brk, ext_en;
   logic [31:0] haddr, hwdata, hrdata, rdn, v;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] ctl_on, d;
   logic [7:0] fmts [8] = '{8'h00, 8'h08, 8'h20, 8'h38,
                            8'h40, 8'h70, 8'h24, 8'h4c};
   wire logic sck_w;
   int err_total, samples_checked, cyc, bitc, i;
   // Pin level: the unit wins while it drives
   assign sck_w = sck_oe ? sck_o : sck_m;
   initial hclk = 1'b0;
   always #20 hclk = ~hclk;
   // Bus answers latched mid-cycle, where they are settled
   always @(negedge hclk) begin
      rdy <= hreadyout;
      rdn <= hrdata;
   end
   ssc_core ssc_core_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .txd_o(txd_o),
      .txd_oe(txd_oe), .rxd_i(rxd_i), .sck_i(sck_w), .sck_o(sck_o),
      .sck_oe(sck_oe));
   ssc_remote_model ssc_remote_model_inst (.txd_o(txd_o),
      .txd_oe(txd_oe), .brk(brk), .ext_en(ext_en), .rxd_i(rxd_i),
      .sck_i(sck_m));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask : chk
   task give_verdict;
      $display("checks %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   // Single word transfer; held until hready is seen high
   task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (rdy !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (rdy !== 1'b1) @(posedge hclk);
      v = rdn;
   endtask : xfer
   // Set up, send one character, watch the line, then read it back
   task frame(input logic [7:0] fmt, input logic [7:0] dd,
              input logic [8:0] st, input logic [3:0] nib,
              input logic [7:0] rx);
      logic [11:0] e;
      int n, k, tot;
      xfer(OFF_CONTROL, 1'b1, 32'h0);
      xfer(OFF_CONTROL, 1'b1, {24'h0, ctl_on & 8'h03});
      xfer(OFF_FORMAT, 1'b1, {24'h0, fmt});
      xfer(OFF_BIT_RATE, 1'b1, 32'h0);
      repeat (bitc) @(posedge hclk);
      xfer(OFF_CONTROL, 1'b1, {24'h0, ctl_on});
      xfer(OFF_TX_HOLD, 1'b1, {24'h0, dd});
      xfer(OFF_STATUS, 1'b1, {23'h0, st});
      n = fmt[6] ? 7 : 8;
      e = 12'hfff;
      e[0] = 1'b0;
      for (k = 0; k < n; k++) e[k + 1] = dd[k];
      if (fmt[2] | fmt[5])
         e[n + 1] = fmt[2] ? st[0] :
            (^(dd & (fmt[6] ? 8'h7f : 8'hff))) ^ fmt[4];
      tot = n + 2 + 32'(fmt[2] | fmt[5]) + 32'(fmt[3]);
      for (k = 0; k < 4000 && txd_o !== 1'b0; k++) @(posedge hclk);
      repeat (bitc / 2) @(posedge hclk);
      for (k = 0; k < tot; k++) begin
         chk(txd_o, e[k]);
         repeat (bitc) @(posedge hclk);
      end
      xfer(OFF_STATUS, 1'b0, 32'h0);
      chk(v[6:3], nib);
      xfer(OFF_RX_HOLD, 1'b0, 32'h0);
      chk(v, rx);
   endtask : frame
   // Hang guard well above the expected run length
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total++;
         give_verdict();
      end
   end
   initial begin
      {hsel, hwrite, haddr, htrans, hwdata, hresetn, brk, ext_en} = '0;
      hsize = 3'h2;
      ctl_on = 8'h30;
      bitc = 32;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      hsel <= 1'b1;
      @(posedge hclk);
      xfer(OFF_BIT_RATE, 1'b0, 32'h0);
      chk(v, {24'h0, RST_BIT_RATE});
      xfer(OFF_STATUS, 1'b0, 32'h0);
      chk(v, 32'h084);
      xfer(8'h40, 1'b0, 32'h0);
      chk(v, 32'h0);
      chk({hresp, txd_o, txd_oe}, 3'b010);
      xfer(OFF_BIT_RATE, 1'b1, 32'h5a);
      xfer(OFF_BIT_RATE, 1'b0, 32'h0);
      chk(v, 32'h5a);
      $display("test reset and rate done");
      for (i = 0; i < 8; i++) begin
         d = 8'(i * 37 + 5);
         frame(fmts[i], d, {8'h0, fmts[i][2] & ~(^d)}, 4'h8,
               fmts[i][6] ? d & 8'h7f : d);
      end
      $display("test formats done");
      // Receiver off keeps its flag and data; transmitter off aborts
      xfer(OFF_CONTROL, 1'b1, 32'h20);
      xfer(OFF_STATUS, 1'b0, 32'h0);
      chk(v[6], 1'b1);
      xfer(OFF_RX_HOLD, 1'b0, 32'h0);
      chk(v, {24'h0, d & 8'h7f});
      xfer(OFF_TX_HOLD, 1'b1, 32'h0f);
      xfer(OFF_STATUS, 1'b1, 32'h040);
      repeat (100) @(posedge hclk);
      xfer(OFF_CONTROL, 1'b1, 32'h0);
      xfer(OFF_STATUS, 1'b0, 32'h0);
      chk({v[7], txd_o, txd_oe}, 3'b110);
      $display("test enables done");
      frame(8'h00, 8'h11, 9'h000, 4'h8, 8'h11);
      frame(8'h00, 8'h22, 9'h040, 4'hc, 8'h11);
      xfer(OFF_STATUS, 1'b1, 32'h080);
      brk <= 1'b1;
      repeat (400) @(posedge hclk);
      brk <= 1'b0;
      repeat (64) @(posedge hclk);
      xfer(OFF_STATUS, 1'b0, 32'h0);
      chk({v[8], v[4]}, 2'b11);
      xfer(OFF_STATUS, 1'b1, 32'h080);
      $display("test errors done");
      xfer(OFF_CONTROL, 1'b1, 32'h01);
      repeat (2) @(posedge hclk);
      chk(sck_oe, 1'b1);
      // Clock out must toggle within 40 bus cycles
      v[0] = sck_o;
      for (i = 0; i < 40 && sck_o === v[0]; i++) @(negedge hclk);
      chk(sck_o !== v[0], 1'b1);
      xfer(OFF_CONTROL, 1'b1, 32'h0);
      repeat (2) @(posedge hclk);
      chk(sck_oe, 1'b0);
      ext_en <= 1'b1;
      ctl_on = 8'h32;
      bitc = 64;
      frame(8'h00, 8'h3c, 9'h000, 4'h8, 8'h3c);
      $display("test clocks done");
      give_verdict();
   end
endmodule : ssc_core_tb_top
`default_nettype wire
